// [design/hps_sequencer.sv]
`timescale 1ns/1ps
`include "hps_consts.svh"
module hps_sequencer #(
  parameter logic [`HPS_CNT_W-1:0] P_STEP_CYC = `HPS_CNT_W'(`HPS_STEP_MS * `HPS_CLK_KHZ)
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_fifo_empty,
  input wire logic i_wave_done,
  output logic [7:0] o_rdata,
  output logic o_boost_en,
  output logic o_amp_en,
  output logic o_playing,
  output hps_pkg::hps_wave_req_t o_wave
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  hps_pkg::hps_ctrl_t ctrl_q;
  logic [7:0] slot_q [`HPS_SLOT_COUNT];
  hps_pkg::hps_state_t state_q;
  logic [2:0] idx_q;
  logic wr_ctrl;
  logic wr_go1;
  logic wr_go0;
  logic busy;
  logic end_now;
  logic start;
  logic cancel;
  logic idle;
  logic [7:0] cur_id;

  // Slot decode is shared by the write and read paths so both always agree on the map.
  function automatic logic is_slot_addr(input logic [7:0] a);
    is_slot_addr = (a >= `HPS_ADDR_SLOT0) && (a <= `HPS_ADDR_SLOT_LAST);
  endfunction : is_slot_addr

  function automatic logic [2:0] slot_index(input logic [7:0] a);
    slot_index = 3'(a - `HPS_ADDR_SLOT0);
  endfunction : slot_index

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign wr_ctrl = i_wr && (i_addr == `HPS_ADDR_CTRL);
  assign wr_go1 = wr_ctrl && i_wdata[`HPS_BIT_GO];
  assign wr_go0 = wr_ctrl && !i_wdata[`HPS_BIT_GO];
  assign busy = (state_q != hps_pkg::HPS_ST_IDLE);
  assign cur_id = slot_q[idx_q];
  assign end_now = ((state_q == hps_pkg::HPS_ST_FETCH) && (cur_id == `HPS_ID_NONE)) // R11
    || ((state_q == hps_pkg::HPS_ST_PLAY) && i_wave_done && (idx_q == `HPS_SLOT_LAST_IDX)); // R12
  // A new start written in the very cycle playback ends wins over the self-clear.
  assign start = wr_go1 && (!ctrl_q.go || end_now); // R5
  assign cancel = wr_go0 && busy; // R8

  // Slot registers.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `HPS_SLOT_COUNT; i++) begin
        slot_q[i] <= `HPS_SLOT_RESET; // R13
      end
    end else if (i_clk_en && i_wr && is_slot_addr(i_addr)) begin
      slot_q[slot_index(i_addr)] <= i_wdata; // R13
    end
  end

  // Control register; the play bit is owned jointly by software and the sequencer.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `HPS_CTRL_RESET; // R2 R3
    end else if (i_clk_en) begin
      if (wr_ctrl) begin
        ctrl_q.timeout <= i_wdata[`HPS_BIT_TMO_HI:`HPS_BIT_TMO_LO];
        ctrl_q.force_on <= i_wdata[`HPS_BIT_FORCE];
      end
      if (start) begin
        ctrl_q.go <= 1'b1; // R5 R6
      end else if (cancel || end_now) begin
        ctrl_q.go <= 1'b0; // R7 R8
      end else if (wr_go0) begin
        ctrl_q.go <= 1'b0;
      end
    end
  end

  // Slot walker.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= hps_pkg::HPS_ST_IDLE;
      idx_q <= 3'h0;
      o_wave <= '0;
    end else if (i_clk_en) begin
      o_wave.start <= 1'b0;
      o_wave.abort <= 1'b0;
      if (cancel) begin
        state_q <= hps_pkg::HPS_ST_IDLE; // R8
        o_wave.abort <= 1'b1;
      end else if (start) begin
        state_q <= hps_pkg::HPS_ST_FETCH; // R9
        idx_q <= 3'h0;
      end else begin
        case (state_q)
          hps_pkg::HPS_ST_IDLE: begin
            idx_q <= 3'h0;
          end
          hps_pkg::HPS_ST_FETCH: begin
            if (cur_id == `HPS_ID_NONE) begin
              state_q <= hps_pkg::HPS_ST_IDLE; // R11
            end else begin
              o_wave.start <= 1'b1; // R14
              o_wave.id <= cur_id;
              state_q <= hps_pkg::HPS_ST_PLAY;
            end
          end
          hps_pkg::HPS_ST_PLAY: begin
            if (i_wave_done) begin
              if (idx_q == `HPS_SLOT_LAST_IDX) begin
                state_q <= hps_pkg::HPS_ST_IDLE; // R12
              end else begin
                idx_q <= idx_q + 3'h1; // R10
                state_q <= hps_pkg::HPS_ST_FETCH;
              end
            end
          end
          default: begin
            state_q <= hps_pkg::HPS_ST_IDLE;
          end
        endcase
      end
    end
  end

  // Playback keeps the output stage awake even though the FIFO is empty.
  hps_idle_timer #(
    .P_STEP_CYC(P_STEP_CYC)
  ) u_idle (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(rst_n),
    .i_clk_en(i_clk_en),
    .i_run(i_fifo_empty && !busy && !ctrl_q.force_on),
    .i_code(ctrl_q.timeout),
    .o_idle(idle)
  );

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_boost_en <= 1'b0;
      o_amp_en <= 1'b0;
      o_playing <= 1'b0;
    end else if (i_clk_en) begin
      o_boost_en <= ctrl_q.force_on || !idle; // R1 R3 R4
      o_amp_en <= ctrl_q.force_on || !idle; // R1 R3 R4
      o_playing <= busy;
    end
  end

  // Register reads; unmapped addresses read as zero.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en && i_rd) begin
      if (i_addr == `HPS_ADDR_CTRL) begin
        o_rdata <= {4'h0, ctrl_q}; // R6
      end else if (is_slot_addr(i_addr)) begin
        o_rdata <= slot_q[slot_index(i_addr)];
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_last_done;
    i_clk_en && state_q == hps_pkg::HPS_ST_PLAY && i_wave_done && idx_q == `HPS_SLOT_LAST_IDX && !wr_ctrl;
  endsequence
  sequence s_back_idle;
    state_q == hps_pkg::HPS_ST_IDLE && !ctrl_q.go;
  endsequence
  sequence s_fetch_live;
    i_clk_en && state_q == hps_pkg::HPS_ST_FETCH && cur_id != `HPS_ID_NONE && !wr_ctrl;
  endsequence

  go_while_busy_a: assert property (busy |-> ctrl_q.go) // R6
    else $error("play bit low while playback runs");
  eighth_slot_end_a: assert property (s_last_done |=> s_back_idle) // R7 R12
    else $error("playback did not end after the eighth slot");
  zero_slot_end_a: assert property (i_clk_en && state_q == hps_pkg::HPS_ST_FETCH && cur_id == `HPS_ID_NONE // R11
    && !wr_ctrl |=> s_back_idle ##0 !o_wave.start)
    else $error("zero identifier did not end playback");
  first_slot_a: assert property (i_clk_en && start && !busy |=> state_q == hps_pkg::HPS_ST_FETCH // R9
    && idx_q == 3'h0 ##1 ((o_wave.start && o_wave.id == $past(slot_q[0]))
    || (state_q == hps_pkg::HPS_ST_IDLE && !ctrl_q.go)))
    else $error("playback did not begin at the first slot");
  next_slot_a: assert property (i_clk_en && state_q == hps_pkg::HPS_ST_PLAY && i_wave_done // R10
    && idx_q != `HPS_SLOT_LAST_IDX && !wr_ctrl |=> state_q == hps_pkg::HPS_ST_FETCH && idx_q == $past(idx_q) + 3'h1)
    else $error("sequencer did not advance to the next slot");
  cancel_stop_a: assert property (i_clk_en && cancel |=> s_back_idle ##0 o_wave.abort) // R8
    else $error("cancel did not stop playback");
  force_hold_a: assert property (i_clk_en && ctrl_q.force_on |=> o_boost_en && o_amp_en) // R4
    else $error("force-on did not hold the enables");
  idle_down_a: assert property (i_clk_en && idle && !ctrl_q.force_on |=> !o_boost_en && !o_amp_en) // R1 R3
    else $error("idle did not power down the output stage");
  slot_write_a: assert property (i_clk_en && i_wr && i_addr == `HPS_ADDR_SLOT0 |=> slot_q[0] == $past(i_wdata)) // R13
    else $error("slot register did not take the written value");
  wave_id_a: assert property (o_wave.start |-> o_wave.id != `HPS_ID_NONE) // R14
    else $error("zero identifier handed to the waveform engine");
  fetch_hand_a: assert property (s_fetch_live |=> o_wave.start && o_wave.id == $past(cur_id)) // R14
    else $error("nonzero identifier was not handed to the waveform engine");
  playing_flag_a: assert property (i_clk_en |=> o_playing == $past(busy)) // R6
    else $error("playing flag does not follow the sequencer");
  idle_go_low_a: assert property (!busy |-> !ctrl_q.go) // R7
    else $error("play bit high while no waveform plays");
endmodule : hps_sequencer

// [design/hps_consts.svh]
// Behaviour
// R1: After the FIFO stays empty for the idle delay, boost and amplifier power down.
// R2: Two-bit idle delay selects 5, 10, 15 or 20 ms; resets to code 0.
// R3: With force-on clear, which is its reset value, device logic drives both enables.
// R4: With force-on set, both enables stay on and idle power-down is ignored.
// R5: Software writes play bit to 1; device plays slots at offsets 0x03 to 0x0A.
// R6: Play bit reads back 1 for the whole time playback runs.
// R7: Play bit clears itself when playback finishes.
// R8: Writing 0 to the play bit during playback cancels it.
// R9: Playback starts by fetching and playing the slot at offset 0x03.
// R10: After each waveform the next slot, from 0x04 onward, is played.
// R11: A slot holding identifier zero ends playback at once, playing nothing.
// R12: Playback ends after the eighth slot even without a zero identifier.
// R13: Each slot register is 8 bits, read/write, reset to zero.
// R14: Each nonzero slot value is handed to the waveform engine as an identifier.
`ifndef HPS_CONSTS_SVH
`define HPS_CONSTS_SVH
`define HPS_ADDR_CTRL 8'h02
`define HPS_ADDR_SLOT0 8'h03
`define HPS_ADDR_SLOT_LAST 8'h0a
`define HPS_SLOT_COUNT 8
`define HPS_SLOT_LAST_IDX 3'h7
`define HPS_BIT_GO 0
`define HPS_BIT_FORCE 1
`define HPS_BIT_TMO_LO 2
`define HPS_BIT_TMO_HI 3
`define HPS_CTRL_RESET 4'h0
`define HPS_SLOT_RESET 8'h00
`define HPS_ID_NONE 8'h00
`define HPS_STEP_MS 5
`define HPS_CLK_KHZ 40000
`define HPS_CNT_W 24
`endif

// [design/hps_pkg.sv]
package hps_pkg;
  typedef enum logic [2:0] {
    HPS_ST_IDLE = 3'h1,
    HPS_ST_FETCH = 3'h2,
    HPS_ST_PLAY = 3'h4
  } hps_state_t;

  typedef struct packed {
    logic [1:0] timeout;
    logic force_on;
    logic go;
  } hps_ctrl_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic [7:0] id;
  } hps_wave_req_t;
endpackage : hps_pkg

// [design/hps_idle_timer.sv]
`timescale 1ns/1ps
`include "hps_consts.svh"
module hps_idle_timer #(
  parameter logic [`HPS_CNT_W-1:0] P_STEP_CYC = `HPS_CNT_W'(`HPS_STEP_MS * `HPS_CLK_KHZ)
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  input wire logic i_run,
  input wire logic [1:0] i_code,
  output logic o_idle
);
  logic [`HPS_CNT_W-1:0] cnt_q;
  logic [`HPS_CNT_W-1:0] lim;

  // Code n waits (n + 1) steps of 5 ms.
  function automatic logic [`HPS_CNT_W-1:0] idle_limit(input logic [1:0] code);
    idle_limit = `HPS_CNT_W'(P_STEP_CYC * (`HPS_CNT_W'(code) + `HPS_CNT_W'(1)));
  endfunction : idle_limit

  assign lim = idle_limit(i_code); // R2

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
      o_idle <= 1'b0;
    end else if (i_clk_en) begin
      if (!i_run) begin
        cnt_q <= '0;
        o_idle <= 1'b0;
      end else if (!o_idle) begin
        if (cnt_q == lim - `HPS_CNT_W'(1)) begin
          o_idle <= 1'b1; // R1
        end
        cnt_q <= cnt_q + `HPS_CNT_W'(1);
      end
    end
  end

  idle_delay_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // R2
    $rose(o_idle) |-> $past(cnt_q) == $past(lim) - `HPS_CNT_W'(1))
    else $error("idle entered before the selected delay");
endmodule : hps_idle_timer

// [bench/hps_wave_engine_model.sv]
`timescale 1ns/1ps
module hps_wave_engine_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input hps_pkg::hps_wave_req_t i_wave,
  input wire logic [3:0] i_lat,
  output logic o_done
);
  int cnt;
  // A cancel drops the waveform in flight so no late done pulse confuses the sequencer.
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_wave.abort) begin
        cnt <= 0;
      end else if (i_wave.start) begin
        cnt <= i_lat + 1;
      end else if (cnt == 1) begin
        o_done <= 1'b1;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : hps_wave_engine_model

// [bench/haptic_playback_sequencer_tb.sv]
`timescale 1ns/1ps
module haptic_playback_sequencer_tb;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, empty = 0, clk_en = 1, done;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
  logic boost, amp, playing;
  logic [3:0] lat = 4'h2;
  hps_pkg::hps_wave_req_t wave;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, aborts = 0;
  logic [7:0] got[$], expq[$];
  always #12.5 clk = ~clk;
  hps_sequencer #(.P_STEP_CYC(24'h00000a)) u_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_clk_en(clk_en),
    .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .i_fifo_empty(empty), .i_wave_done(done),
    .o_rdata(rdata), .o_boost_en(boost), .o_amp_en(amp), .o_playing(playing), .o_wave(wave));
  hps_wave_engine_model u_eng (.i_ref_clk(clk), .i_rst_b(rst_b), .i_wave(wave), .i_lat(lat), .o_done(done));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wave.start === 1'b1) got.push_back(wave.id);
    if (wave.abort === 1'b1) aborts <= aborts + 1;
    if (cyc > 20000) begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1; addr = a; wdata = d;
    @(negedge clk);
    wr = 0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd = 1; addr = a;
    @(negedge clk);
    rd = 0;
    d = rdata;
  endtask : reg_rd
  // Plays a sequence with n nonzero slots; the zero slot after them, or the eighth slot when n is 8, must stop playback.
  task automatic play(input int n);
    int k;
    expq.delete(); got.delete();
    for (k = 0; k < 8; k++) begin
      wdata = (k < n) ? 8'($urandom) | 8'h01 : 8'h00;
      if (k < n) expq.push_back(wdata);
      reg_wr(8'h03 + 8'(k), wdata);
    end
    lat = 4'($urandom % 5);
    reg_wr(8'h02, 8'h01);
    wait_n(3);
    if (n > 0) begin
      reg_rd(8'h02, rv);
      chk("go_busy", 8'h01, rv);
    end
    k = 0;
    while (playing !== 1'b0 && k < 500) begin
      wait_n(1);
      k++;
    end
    reg_rd(8'h02, rv);
    chk("go_end", 8'h00, rv);
    chk("count", 8'(expq.size()), 8'(got.size()));
    for (k = 0; k < expq.size() && k < got.size(); k++) chk("id", expq[k], got[k]);
  endtask : play
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  initial begin
    int c;
    void'($urandom(32'ha314));
    wait_n(12);
    rst_b = 1;
    wait_n(3);
    for (c = 2; c <= 11; c++) begin
      reg_rd(8'(c), rv);
      chk("reset", 8'h00, rv);
    end
    for (c = 3; c <= 10; c++) begin
      wdata = 8'($urandom);
      reg_wr(8'(c), wdata);
      reg_rd(8'(c), rv);
      chk("slot_rw", wdata, rv);
    end
    reg_wr(8'h03, 8'h11);
    clk_en = 0;
    reg_wr(8'h03, 8'h22);
    clk_en = 1;
    reg_rd(8'h03, rv);
    chk("frozen_wr", 8'h11, rv);
    $display("test registers done");
    for (c = 0; c <= 8; c++) play(c);
    $display("test playback done");
    play(8);
    lat = 4'hf;
    reg_wr(8'h02, 8'h01);
    wait_n(4);
    reg_wr(8'h02, 8'h00);
    wait_n(3);
    chk("abort", 8'h01, 8'(aborts));
    chk("cancel_busy", 8'h00, {7'h00, playing});
    $display("test cancel done");
    for (c = 0; c < 4; c++) begin
      reg_wr(8'h02, 8'(c << 2));
      reg_rd(8'h02, rv);
      chk("delay_code", 8'(c << 2), rv);
      empty = 1;
      wait_n((c + 1) * 10);
      chk("en_before", 8'h03, {6'h00, boost, amp});
      wait_n(1);
      chk("en_idle", 8'h00, {6'h00, boost, amp});
      reg_wr(8'h02, 8'(c << 2) | 8'h02);
      wait_n(25);
      chk("en_force", 8'h03, {6'h00, boost, amp});
      reg_wr(8'h02, 8'(c << 2));
      wait_n((c + 1) * 10 + 1);
      chk("en_relapse", 8'h00, {6'h00, boost, amp});
      reg_wr(8'h02, 8'h00);
      empty = 0;
      wait_n(3);
      chk("en_logic", 8'h03, {6'h00, boost, amp});
    end
    $display("test idle done");
    rst_b = 0;
    wait_n(2);
    rst_b = 1;
    wait_n(3);
    chk("en_reset", 8'h03, {6'h00, boost, amp});
    for (c = 2; c <= 10; c++) begin
      reg_rd(8'(c), rv);
      chk("rereset", 8'h00, rv);
    end
    $display("test reset done");
    test_done();
  end
endmodule : haptic_playback_sequencer_tb
